/* File: bench/scs_ctrl_model.sv */
// Model of the upper controller that drives the input terminals.
// Assumes the bench posts terminal requests on the rising CLOCK edge.
`timescale 1ns/1ps
`default_nettype none
module scs_ctrl_model (
  input  wire logic       CLOCK,
  input  wire logic [3:0] req_di,
  input  wire logic       req_trig,
  input  wire logic [2:0] req_sel,
  output logic      [3:0] di,
  output logic            trig,
  output logic      [2:0] sel
);
  // ==========================================================================
  // Terminal drive.
  initial begin
    di   = 4'h0;
    trig = 1'b0;
    sel  = 3'h0;
  end
  // Terminals change just after a rising edge and then hold their level.
  always @(posedge CLOCK) begin
    di   <= req_di;
    trig <= req_trig;
    sel  <= req_sel;
  end
endmodule
`default_nettype wire

/* File: bench/test_servo_command_select.sv */
// Self-checking bench of the servo command selector.
// Assumes the design top, its package and the terminal model.
`timescale 1ns/1ps
`default_nettype none
module test_servo_command_select;
  logic        clock, srst, psel, penable, pwrite, run_ready;
  logic        pready, pslverr, enabled, complete, err, trig, req_trig;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, command, rd;
  logic [15:0] analog_in;
  logic [3:0]  req_di, di;
  logic [2:0]  req_sel, sel, seg_index;
  int          fails, n_compared;
  int          bits [11] = '{2, 0, 0, 1, 2, 1, 0, 0, 0, 0, 0};
  int          exp  [11] = '{0, 1, 2, 1, 0, 0, 1, 2, 3, 4, 4};

  scs_top scs_top_inst (.CLOCK(clock), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DIGITAL_INPUT_1(di[0]), .DIGITAL_INPUT_2(di[1]),
    .DIGITAL_INPUT_3(di[2]), .DIGITAL_INPUT_4(di[3]),
    .SEGMENT_TRIGGER(trig), .SEGMENT_SELECT_B0(sel[0]),
    .SEGMENT_SELECT_B1(sel[1]), .SEGMENT_SELECT_B2(sel[2]),
    .ANALOG_IN(analog_in), .RUN_READY(run_ready), .SERVO_ENABLED(enabled),
    .POSITION_COMPLETE(complete), .COMMAND(command),
    .SEGMENT_INDEX(seg_index));
  scs_ctrl_model scs_ctrl_model_inst (.CLOCK(clock), .req_di(req_di),
    .req_trig(req_trig), .req_sel(req_sel), .di(di), .trig(trig),
    .sel(sel));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================================================
  // Shared tasks.
  task automatic close_out;
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      fails++;
      $display("[ERR] %0t value %h expected %h", $time, got, want);
    end
  endtask
  task automatic chk_bit(input logic got, input logic want);
    n_compared++;
    if (got !== want) begin
      fails++;
      $display("[ERR] %0t flag %b expected %b", $time, got, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk_val(rd, want);
  endtask
  task automatic pins(input logic [3:0] d, input logic t,
                      input logic [2:0] s, input int n);
    req_di   <= d;
    req_trig <= t;
    req_sel  <= s;
    cyc(n);
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    while (complete !== 1'b1 && k < 400) begin
      @(posedge clock);
      k++;
    end
    chk_bit(complete, 1'b1);
  endtask
  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    chk_bit(enabled, 1'b0);
    chk_bit(complete, 1'b1);
    chk_val(command, 32'h0);
    rd_chk(scs_pkg::ADDR_CTRL, scs_pkg::CTRL_RESET);
    rd_chk(scs_pkg::ADDR_DIFUNC, scs_pkg::DIFUNC_RESET);
    rd_chk(scs_pkg::ADDR_SEQ, scs_pkg::SEQ_RESET);
    rd_chk(12'hffc, 32'h0);
    chk_bit(err, 1'b1);
  endtask
  task automatic t_enable;
    for (int i = 0; i < 8; i++)
      apb(1'b1, scs_pkg::ADDR_SPD_BASE + 12'(i * 4), 32'h1000 + i);
    apb(1'b1, scs_pkg::ADDR_DIFUNC, 32'h100f_0e01);
    apb(1'b1, scs_pkg::ADDR_CTRL, 32'h0000_0101);
    pins(4'b0110, 1'b0, 3'h0, 6);
    chk_bit(enabled, 1'b0);
    chk_val(command, 32'h0);
    pins(4'b0111, 1'b0, 3'h0, 6);
    chk_bit(enabled, 1'b1);
    chk_val(command, 32'h1003);
    pins(4'b0000, 1'b0, 3'h0, 1);
    apb(1'b1, scs_pkg::ADDR_CTRL, 32'h0000_0121);
    cyc(5);
    chk_bit(enabled, 1'b1);
    chk_val(command, 32'h1000);
    for (int i = 0; i < 8; i++) begin
      pins({3'(i), 1'b1}, 1'b0, 3'h0, 6);
      chk_val(command, 32'h1000 + i);
    end
  endtask
  task automatic t_analog;
    analog_in <= 16'h0123;
    apb(1'b1, scs_pkg::ADDR_CTRL, 32'h0000_0021);
    cyc(5);
    chk_val(command, 32'h0000_0123);
    run_ready <= 1'b1;
    apb(1'b1, scs_pkg::ADDR_CTRL, 32'h0000_0821);
    cyc(5);
    rd_chk(scs_pkg::ADDR_SPD_OFS, 32'h0000_0123);
    chk_val(command, 32'h0);
  endtask
  task automatic t_torque;
    for (int i = 0; i < 4; i++)
      apb(1'b1, scs_pkg::ADDR_TRQ_BASE + 12'(i * 4), 32'h2000 + i);
    apb(1'b1, scs_pkg::ADDR_DIFUNC, 32'h0012_1101);
    apb(1'b1, scs_pkg::ADDR_CTRL, 32'h0000_0426);
    for (int i = 0; i < 4; i++) begin
      pins({1'b0, 2'(i), 1'b1}, 1'b0, 3'h0, 6);
      chk_val(command, 32'h2000 + i);
    end
    analog_in <= 16'h0045;
    apb(1'b1, scs_pkg::ADDR_CTRL, 32'h0000_0026);
    cyc(5);
    chk_val(command, 32'h0000_0045);
    apb(1'b1, scs_pkg::ADDR_CTRL, 32'h0000_1026);
    cyc(5);
    rd_chk(scs_pkg::ADDR_TRQ_OFS, 32'h0000_0045);
  endtask
  task automatic t_seq;
    for (int i = 0; i < 8; i++)
      apb(1'b1, scs_pkg::ADDR_POS_BASE + 12'(i * 4), 32'h3000 + i);
    apb(1'b1, scs_pkg::ADDR_DIFUNC, 32'h0000_0001);
    apb(1'b1, scs_pkg::ADDR_CTRL, 32'h0000_0220);
    apb(1'b1, scs_pkg::ADDR_SEQ, 32'h0000_0040);
    pins(4'b0001, 1'b1, 3'h0, 4);
    chk_bit(complete, 1'b0);
    pins(4'b0001, 1'b0, 3'h0, 3);
    pins(4'b0001, 1'b1, 3'h0, 3);
    pins(4'b0001, 1'b0, 3'h0, 1);
    wait_done;
    chk_val(32'(seg_index), 32'h0);
    cyc(6);
    chk_bit(complete, 1'b1);
    apb(1'b1, scs_pkg::ADDR_SEQ, 32'h0000_0042);
    pins(4'b0001, 1'b1, 3'h5, 3);
    pins(4'b0001, 1'b0, 3'h5, 4);
    chk_val(32'(seg_index), 32'h5);
    chk_val(command, 32'h3005);
    chk_bit(complete, 1'b0);
    wait_done;
    apb(1'b1, scs_pkg::ADDR_SEQ, 32'h0000_0043);
    pins(4'b0001, 1'b0, 3'h0, 2);
    for (int i = 0; i < 11; i++) begin
      pins(4'b0001, 1'b0, 3'(1 << bits[i]), 3);
      pins(4'b0001, 1'b0, 3'h0, 3);
      wait_done;
      chk_val(32'(seg_index), 32'(exp[i]));
      chk_val(command, 32'h3000 + 32'(exp[i]));
    end
    apb(1'b1, scs_pkg::ADDR_SEQ, 32'h0000_0041);
    pins(4'b0001, 1'b1, 3'h0, 120);
    chk_bit(complete, 1'b0);
    pins(4'b0001, 1'b0, 3'h0, 1);
    wait_done;
  endtask
  // ==========================================================================
  // Main sequence and watchdog.
  initial begin
    fails = 0;
    n_compared = 0;
    srst = 1'b1;
    {psel, penable, pwrite, run_ready} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    analog_in = 16'h0000;
    req_di = 4'h0;
    req_trig = 1'b0;
    req_sel = 3'h0;
    cyc(2);
    srst <= 1'b0;
    t_reset;
    t_enable;
    t_analog;
    t_torque;
    t_seq;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    close_out;
  end
endmodule
`default_nettype wire

/* File: design/scs_pkg.sv */
// Constants, register map and state codes of the servo command selector.
// Assumes one 250 MHz clock and an APB register bus of 32-bit words.
package scs_pkg;
  // ==========================================================================
  // Register offsets.
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_DIFUNC   = 12'h004;
  localparam logic [11:0] ADDR_SEQ      = 12'h008;
  localparam logic [11:0] ADDR_STATUS   = 12'h00c;
  localparam logic [11:0] ADDR_COMMAND  = 12'h010;
  localparam logic [11:0] ADDR_ANALOG   = 12'h014;
  localparam logic [11:0] ADDR_SPD_OFS  = 12'h018;
  localparam logic [11:0] ADDR_TRQ_OFS  = 12'h01c;
  localparam logic [11:0] ADDR_POS_BASE = 12'h040;
  localparam logic [11:0] ADDR_SPD_BASE = 12'h080;
  localparam logic [11:0] ADDR_TRQ_BASE = 12'h0a0;
  // ==========================================================================
  // Field positions of the control register.
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_FORCE_LSB = 4;
  localparam int CTRL_SPDSRC    = 8;
  localparam int CTRL_POSSRC    = 9;
  localparam int CTRL_TRQSRC    = 10;
  localparam int CTRL_ZERO_SPD  = 11;
  localparam int CTRL_ZERO_TRQ  = 12;
  // Field positions of the sequence register.
  localparam int SEQ_MODE_LSB   = 0;
  localparam int SEQ_COUNT_LSB  = 4;
  // ==========================================================================
  // Parameter values with a meaning.
  localparam logic [3:0] MODE_POSITION = 4'h0;
  localparam logic [3:0] MODE_SPEED    = 4'h1;
  localparam logic [3:0] MODE_TORQUE   = 4'h6;
  localparam logic [1:0] FORCE_ON      = 2'h2;
  localparam logic [7:0] FUNC_SERVO_ON = 8'h01;
  localparam logic [7:0] FUNC_SPD_B0   = 8'h0e;
  localparam logic [7:0] FUNC_SPD_B1   = 8'h0f;
  localparam logic [7:0] FUNC_SPD_B2   = 8'h10;
  localparam logic [7:0] FUNC_TRQ_B0   = 8'h11;
  localparam logic [7:0] FUNC_TRQ_B1   = 8'h12;
  // ==========================================================================
  // Reset values.
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] DIFUNC_RESET = 32'h0000_0001;
  localparam logic [31:0] SEQ_RESET    = 32'h0000_0080;
  // ==========================================================================
  // Timing: dwell of a simulated move, in cycles.
  localparam logic [7:0] MOVE_CYCLES   = 8'h10;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_MOVE = 2'b01,
    SEQ_HOME = 2'b10
  } scs_seq_type;
endpackage

/* File: design/scs_top.sv */
// Servo command selector: enable, mode choice, select decode, sequencer.
// Assumes synchronous input pins and an APB master on CLOCK.
`timescale 1ns/1ps
`default_nettype none
module scs_top (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        DIGITAL_INPUT_1,
  input  wire logic        DIGITAL_INPUT_2,
  input  wire logic        DIGITAL_INPUT_3,
  input  wire logic        DIGITAL_INPUT_4,
  input  wire logic        SEGMENT_TRIGGER,
  input  wire logic        SEGMENT_SELECT_B0,
  input  wire logic        SEGMENT_SELECT_B1,
  input  wire logic        SEGMENT_SELECT_B2,
  input  wire logic [15:0] ANALOG_IN,
  input  wire logic        RUN_READY,
  output logic             SERVO_ENABLED,
  output logic             POSITION_COMPLETE,
  output logic      [31:0] COMMAND,
  output logic       [2:0] SEGMENT_INDEX
);
  // ==========================================================================
  // Register storage.
  logic [31:0] ctrl;
  logic [31:0] difunc;
  logic [31:0] seq;
  logic [31:0] spd_ofs;
  logic [31:0] trq_ofs;
  logic [31:0] pos_tab [8];
  logic [31:0] spd_tab [8];
  logic [31:0] trq_tab [4];
  logic [3:0]  mode;
  logic [1:0]  seq_mode;
  logic [2:0]  seg_last;
  logic        enabled;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [31:0] next_rdata;
  logic        zero_spd_go;
  logic        zero_trq_go;

  assign mode     = ctrl[scs_pkg::CTRL_MODE_LSB +: 4];
  assign seq_mode = seq[scs_pkg::SEQ_MODE_LSB +: 2];
  assign seg_last = seq[scs_pkg::SEQ_COUNT_LSB +: 3];
  assign wr       = PSEL && PENABLE && PWRITE;
  assign rd       = PSEL && PENABLE && !PWRITE;
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL && PENABLE && !hit;

  // ==========================================================================
  // Enable.
  // servo-on sources
  assign enabled = (difunc[7:0] == scs_pkg::FUNC_SERVO_ON && DIGITAL_INPUT_1)
                || ctrl[scs_pkg::CTRL_FORCE_LSB +: 2] == scs_pkg::FORCE_ON;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      SERVO_ENABLED <= 1'b0;
    end else begin
      SERVO_ENABLED <= enabled;
    end
  end

  // ==========================================================================
  // Register writes.
  assign zero_spd_go = wr && PADDR == scs_pkg::ADDR_CTRL
                    && PWDATA[scs_pkg::CTRL_ZERO_SPD];
  assign zero_trq_go = wr && PADDR == scs_pkg::ADDR_CTRL
                    && PWDATA[scs_pkg::CTRL_ZERO_TRQ];

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ctrl   <= scs_pkg::CTRL_RESET;
      difunc <= scs_pkg::DIFUNC_RESET;
      seq    <= scs_pkg::SEQ_RESET;
      for (int i = 0; i < 8; i++) begin
        pos_tab[i] <= 32'h0000_0000;
        spd_tab[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < 4; i++) begin
        trq_tab[i] <= 32'h0000_0000;
      end
    end else if (wr) begin
      if (PADDR == scs_pkg::ADDR_CTRL) begin
        ctrl <= {21'h0, PWDATA[10:0]};
      end else if (PADDR == scs_pkg::ADDR_DIFUNC) begin
        difunc <= PWDATA;
      end else if (PADDR == scs_pkg::ADDR_SEQ) begin
        seq <= {25'h0, PWDATA[6:0]};
      end else if (PADDR[11:5] == scs_pkg::ADDR_POS_BASE[11:5]) begin
        pos_tab[PADDR[4:2]] <= PWDATA;
      end else if (PADDR[11:5] == scs_pkg::ADDR_SPD_BASE[11:5]) begin
        spd_tab[PADDR[4:2]] <= PWDATA;
      end else if (PADDR[11:4] == scs_pkg::ADDR_TRQ_BASE[11:4]) begin
        trq_tab[PADDR[3:2]] <= PWDATA;
      end
    end
  end

  // ==========================================================================
  // Zero-drift compensation stores the present analog reading.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      spd_ofs <= 32'h0000_0000;
      trq_ofs <= 32'h0000_0000;
    end else if (RUN_READY && enabled) begin
      if (zero_spd_go) begin
        spd_ofs <= {{16{ANALOG_IN[15]}}, ANALOG_IN};
      end
      if (zero_trq_go) begin
        trq_ofs <= {{16{ANALOG_IN[15]}}, ANALOG_IN};
      end
    end
  end

  // ==========================================================================
  // Select decode.
  logic [2:0] spd_sel;
  logic [1:0] trq_sel;
  assign spd_sel[0] = difunc[15:8]  == scs_pkg::FUNC_SPD_B0 && DIGITAL_INPUT_2;
  assign spd_sel[1] = difunc[23:16] == scs_pkg::FUNC_SPD_B1 && DIGITAL_INPUT_3;
  assign spd_sel[2] = difunc[31:24] == scs_pkg::FUNC_SPD_B2 && DIGITAL_INPUT_4;
  assign trq_sel[0] = difunc[15:8]  == scs_pkg::FUNC_TRQ_B0 && DIGITAL_INPUT_2;
  assign trq_sel[1] = difunc[23:16] == scs_pkg::FUNC_TRQ_B1 && DIGITAL_INPUT_3;

  // ==========================================================================
  // Position sequencer.
  scs_pkg::scs_seq_type state;
  logic [2:0] seg;
  logic [7:0] dwell;
  logic       trig_q;
  logic [2:0] sel_q;
  logic       pos_mode;
  logic       trig_rise;
  logic       trig_fall;
  logic [2:0] sel_rise;
  assign pos_mode  = mode == scs_pkg::MODE_POSITION
                   && ctrl[scs_pkg::CTRL_POSSRC];
  assign trig_rise = SEGMENT_TRIGGER && !trig_q;
  assign trig_fall = !SEGMENT_TRIGGER && trig_q;
  assign sel_rise  = {SEGMENT_SELECT_B2, SEGMENT_SELECT_B1, SEGMENT_SELECT_B0}
                   & ~sel_q;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      trig_q <= 1'b0;
      sel_q  <= 3'h0;
    end else begin
      trig_q <= SEGMENT_TRIGGER;
      sel_q  <= {SEGMENT_SELECT_B2, SEGMENT_SELECT_B1, SEGMENT_SELECT_B0};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state <= scs_pkg::SEQ_IDLE;
      seg   <= 3'h0;
      dwell <= 8'h00;
      POSITION_COMPLETE <= 1'b1;
    end else if (!enabled || !pos_mode) begin
      state <= scs_pkg::SEQ_IDLE;
      dwell <= 8'h00;
      POSITION_COMPLETE <= 1'b1;
    end else begin
      case (state)
        scs_pkg::SEQ_IDLE: begin
          if (POSITION_COMPLETE) begin
            case (seq_mode)
              2'd0, 2'd1: begin
                if ((seq_mode == 2'd0 && trig_rise)
                    || (seq_mode == 2'd1 && SEGMENT_TRIGGER)) begin
                  seg   <= 3'h0;
                  state <= scs_pkg::SEQ_MOVE;
                  dwell <= scs_pkg::MOVE_CYCLES;
                  POSITION_COMPLETE <= 1'b0;
                end
              end
              2'd2: begin
                if (trig_fall) begin
                  seg   <= {SEGMENT_SELECT_B2, SEGMENT_SELECT_B1,
                            SEGMENT_SELECT_B0};
                  state <= scs_pkg::SEQ_HOME;
                  dwell <= scs_pkg::MOVE_CYCLES;
                  POSITION_COMPLETE <= 1'b0;
                end
              end
              default: begin
                if (sel_rise[2]) begin
                  seg <= 3'h0;
                end else if (sel_rise[1]) begin
                  seg <= (seg == 3'h0) ? 3'h0 : seg - 3'h1;
                end else if (sel_rise[0]) begin
                  seg <= (seg >= seg_last) ? seg : seg + 3'h1;
                end
                if (sel_rise != 3'h0) begin
                  state <= scs_pkg::SEQ_HOME;
                  dwell <= scs_pkg::MOVE_CYCLES;
                  POSITION_COMPLETE <= 1'b0;
                end
              end
            endcase
          end
        end
        scs_pkg::SEQ_MOVE: begin
          if (dwell != 8'h00) begin
            dwell <= dwell - 8'h01;
          end else if (seg < seg_last) begin
            seg   <= seg + 3'h1;
            dwell <= scs_pkg::MOVE_CYCLES;
          end else if (seq_mode == 2'd1 && SEGMENT_TRIGGER) begin
            seg   <= 3'h0;
            dwell <= scs_pkg::MOVE_CYCLES;
          end else begin
            // Return to the first location and finish.
            seg   <= 3'h0;
            state <= scs_pkg::SEQ_HOME;
            dwell <= scs_pkg::MOVE_CYCLES;
          end
        end
        scs_pkg::SEQ_HOME: begin
          if (dwell != 8'h00) begin
            dwell <= dwell - 8'h01;
          end else begin
            state <= scs_pkg::SEQ_IDLE;
            POSITION_COMPLETE <= 1'b1;
          end
        end
        default: begin
          state <= scs_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Command output.
  logic [31:0] next_command;
  always_comb begin
    next_command = 32'h0000_0000;
    if (!enabled) begin
      next_command = 32'h0000_0000;
    end else if (pos_mode) begin
      next_command = pos_tab[seg];
    end else if (mode == scs_pkg::MODE_SPEED) begin
      next_command = ctrl[scs_pkg::CTRL_SPDSRC] ? spd_tab[spd_sel]
                   : {{16{ANALOG_IN[15]}}, ANALOG_IN} - spd_ofs;
    end else if (mode == scs_pkg::MODE_TORQUE) begin
      next_command = ctrl[scs_pkg::CTRL_TRQSRC] ? trq_tab[trq_sel]
                   : {{16{ANALOG_IN[15]}}, ANALOG_IN} - trq_ofs;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      COMMAND       <= 32'h0000_0000;
      SEGMENT_INDEX <= 3'h0;
    end else begin
      COMMAND       <= next_command;
      SEGMENT_INDEX <= seg;
    end
  end

  // ==========================================================================
  // Register reads.
  always_comb begin
    next_rdata = 32'h0000_0000;
    hit        = 1'b1;
    if (PADDR == scs_pkg::ADDR_CTRL) begin
      next_rdata = ctrl;
    end else if (PADDR == scs_pkg::ADDR_DIFUNC) begin
      next_rdata = difunc;
    end else if (PADDR == scs_pkg::ADDR_SEQ) begin
      next_rdata = seq;
    end else if (PADDR == scs_pkg::ADDR_STATUS) begin
      next_rdata = {25'h0, seg, state, POSITION_COMPLETE, SERVO_ENABLED};
    end else if (PADDR == scs_pkg::ADDR_COMMAND) begin
      next_rdata = COMMAND;
    end else if (PADDR == scs_pkg::ADDR_ANALOG) begin
      next_rdata = {16'h0, ANALOG_IN};
    end else if (PADDR == scs_pkg::ADDR_SPD_OFS) begin
      next_rdata = spd_ofs;
    end else if (PADDR == scs_pkg::ADDR_TRQ_OFS) begin
      next_rdata = trq_ofs;
    end else if (PADDR[11:5] == scs_pkg::ADDR_POS_BASE[11:5]) begin
      next_rdata = pos_tab[PADDR[4:2]];
    end else if (PADDR[11:5] == scs_pkg::ADDR_SPD_BASE[11:5]) begin
      next_rdata = spd_tab[PADDR[4:2]];
    end else if (PADDR[11:4] == scs_pkg::ADDR_TRQ_BASE[11:4]) begin
      next_rdata = trq_tab[PADDR[3:2]];
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= next_rdata;
    end
  end

  // ==========================================================================
  // Checks.
  chk_force_enable: assert property (@(posedge CLOCK) disable iff (SRST)
    ctrl[5:4] == scs_pkg::FORCE_ON |=> SERVO_ENABLED)
    else $error("Forced enable did not enable.");
  chk_di_enable: assert property (@(posedge CLOCK) disable iff (SRST)
    difunc[7:0] == 8'h01 && DIGITAL_INPUT_1 |=> SERVO_ENABLED)
    else $error("Servo-on input ignored.");
  chk_busy_ignore: assert property (@(posedge CLOCK) disable iff (SRST)
    enabled && pos_mode && state == scs_pkg::SEQ_MOVE && dwell != 8'h00
    |=> !POSITION_COMPLETE)
    else $error("Completion during motion.");
  chk_fall_start: assert property (@(posedge CLOCK) disable iff (SRST)
    enabled && pos_mode && seq_mode == 2'd2 && state == scs_pkg::SEQ_IDLE
    && trig_fall |=> !POSITION_COMPLETE
    && seg == $past({SEGMENT_SELECT_B2, SEGMENT_SELECT_B1,
                     SEGMENT_SELECT_B0}))
    else $error("Falling edge did not start move.");
  chk_home_jump: assert property (@(posedge CLOCK) disable iff (SRST)
    enabled && pos_mode && seq_mode == 2'd3 && state == scs_pkg::SEQ_IDLE
    && sel_rise[2] |=> seg == 3'h0)
    else $error("Home select missed.");
  chk_prev_clamp: assert property (@(posedge CLOCK) disable iff (SRST)
    enabled && pos_mode && seq_mode == 2'd3 && state == scs_pkg::SEQ_IDLE
    && sel_rise == 3'b010 && seg == 3'h0 |=> seg == 3'h0)
    else $error("Previous stepped below first.");
  chk_move_done: assert property (@(posedge CLOCK) disable iff (SRST)
    state == scs_pkg::SEQ_HOME && dwell == 8'h00 && enabled && pos_mode
    |=> POSITION_COMPLETE ##1 SEGMENT_INDEX == $past(seg, 2))
    else $error("Move end without completion.");
  chk_zero_cmd: assert property (@(posedge CLOCK) disable iff (SRST)
    !enabled |=> COMMAND == 32'h0000_0000)
    else $error("Command nonzero while disabled.");
  chk_speed_sel: assert property (@(posedge CLOCK) disable iff (SRST)
    enabled && mode == scs_pkg::MODE_SPEED && ctrl[8]
    |=> COMMAND == $past(spd_tab[spd_sel]))
    else $error("Wrong internal speed.");
  cov_once: cover property (@(posedge CLOCK) seq_mode == 2'd0 && trig_rise
    && POSITION_COMPLETE && pos_mode && enabled);
  cov_loop: cover property (@(posedge CLOCK) seq_mode == 2'd1
    && state == scs_pkg::SEQ_MOVE);
  cov_torque: cover property (@(posedge CLOCK) enabled
    && mode == scs_pkg::MODE_TORQUE);
endmodule
`default_nettype wire
